// ---- hdl/synth_pkg.sv ----
package synth_pkg;

	// register byte offsets on the wishbone slave
	localparam logic [7:0] OFS_SPACING   = 8'h00;
	localparam logic [7:0] OFS_BASE_LOW  = 8'h04;
	localparam logic [7:0] OFS_BASE_HIGH = 8'h08;
	localparam logic [7:0] OFS_CHAN_LOW  = 8'h0c;
	localparam logic [7:0] OFS_MODE      = 8'h10;
	localparam logic [7:0] OFS_PLL_STAT  = 8'h14;
	localparam logic [7:0] OFS_FREQ      = 8'h18;

	// reset values of the channel registers
	localparam logic [7:0] RST_SPACING   = 8'h08;
	localparam logic [7:0] RST_BASE_LOW  = 8'hf8;
	localparam logic [7:0] RST_BASE_HIGH = 8'h8c;
	localparam logic [7:0] RST_CHAN_LOW  = 8'h00;
	localparam logic [7:0] RST_MODE      = 8'h00;

	// channel mode register fields
	localparam int SCHEME_MSB = 7;
	localparam int SCHEME_LSB = 6;
	localparam int CNH_BIT    = 0;
	localparam logic [7:0] MODE_WMASK = 8'hc1;

	// pll status register fields
	localparam int STAT_ENABLE_BIT = 0;
	localparam int STAT_LOCK_BIT   = 1;
	localparam int STAT_BUSY_BIT   = 2;

	// channel schemes
	localparam logic [1:0] SCHEME_IEEE  = 2'h0;
	localparam logic [1:0] SCHEME_FINE1 = 2'h1;
	localparam logic [1:0] SCHEME_FINE2 = 2'h2;
	localparam logic [1:0] SCHEME_FINE3 = 2'h3;

	// transceiver state codes on the state input
	localparam logic [1:0] transceiver_off_state  = 2'h0;
	localparam logic [1:0] transmit_prepare_state = 2'h1;
	localparam logic [1:0] TRX_TX                 = 2'h2;
	localparam logic [1:0] TRX_RX                 = 2'h3;

	// frequency arithmetic, in hz except the fine shift count
	localparam logic [31:0] IEEE_UNIT_HZ  = 32'h000061a8;
	localparam logic [31:0] OFFSET_SUB_HZ = 32'h00000000;
	localparam logic [31:0] OFFSET_24_HZ  = 32'h59682f00;
	localparam logic [31:0] FINE1_BASE_HZ = 32'h16789040;
	localparam logic [31:0] FINE2_BASE_HZ = 32'h2cf12080;
	localparam logic [31:0] FINE3_BASE_HZ = 32'h8d064b80;
	localparam logic [31:0] FINE1_STEP_HZ = 32'h00632ea0;
	localparam logic [31:0] FINE2_STEP_HZ = 32'h00c65d40;
	localparam logic [31:0] FINE3_STEP_HZ = 32'h018cba80;
	localparam int          FINE_SHIFT    = 16;

	// cycles after a tune start before lock is believed
	localparam int TUNE_HOLD_CYCLES = 4;

endpackage

// ---- hdl/channel_freq_calc.sv ----
module channel_freq_calc
	import synth_pkg::*;
#(
	parameter bit SUB_GHZ = 1'b1
) (
	// applied channel settings
	input  wire logic [1:0]  scheme,
	input  wire logic [15:0] base_freq,
	input  wire logic [8:0]  chan_num,
	input  wire logic [7:0]  spacing,
	input  wire logic [23:0] fine_num,
	// resulting carrier frequency in hz
	output logic      [31:0] freq_hz
);

	// base + step * n / 2^16, shared by the three fine schemes
	function automatic logic [31:0] fine_freq(input logic [31:0] base, input logic [31:0] step,
		input logic [23:0] n);
		logic [55:0] prod;
		prod = 56'(step) * 56'(n);
		return base + prod[FINE_SHIFT +: 32];
	endfunction

	logic [17:0] units;
	logic [33:0] ieee_prod;
	logic [31:0] ieee_freq;

	// ieee scheme: (base + n * spacing) * 25khz + band offset
	always_comb begin
		units = {2'h0, base_freq} + 18'(chan_num * spacing);
		ieee_prod = 34'(units) * 34'(IEEE_UNIT_HZ);
		ieee_freq = ieee_prod[31:0] + (SUB_GHZ ? OFFSET_SUB_HZ : OFFSET_24_HZ);
	end

	// scheme selection, the caller has already filtered schemes per band
	always_comb begin
		unique case (scheme)
			SCHEME_IEEE:  freq_hz = ieee_freq;
			SCHEME_FINE1: freq_hz = fine_freq(FINE1_BASE_HZ, FINE1_STEP_HZ, fine_num);
			SCHEME_FINE2: freq_hz = fine_freq(FINE2_BASE_HZ, FINE2_STEP_HZ, fine_num);
			SCHEME_FINE3: freq_hz = fine_freq(FINE3_BASE_HZ, FINE3_STEP_HZ, fine_num);
		endcase
	end

endmodule

// ---- hdl/synth_channel_config.sv ----
// Functional notes
// - synthesizer runs only in prepare, transmit, receive
// - ready interrupt when prepare reached from off
// - tune pll after calibrations on off exit
// - applied channel change in prepare retunes, ready
// - lock loss gives error, relock gives ready
// - each off exit restarts pll settling
// - lock condition readable as status bit
// - only mode write applies channel registers
// - mode zero: (base + n*spacing)*25khz + offset
// - base value is high and low bytes
// - channel number: low register plus high bit
// - spacing is eight bits of 25khz
// - offset zero sub-ghz, 1.5ghz for 2.4ghz
// - mode one: 377mhz plus 6.5mhz*n/65536
// - fine number is high, low, channel bytes
// - mode one ignored on the 2.4ghz synthesizer
// - accepted modes depend on frequency band
// - mode bits 7:6, high channel bit 0
// - lock bit reads one when locked
module synth_channel_config
	import synth_pkg::*;
#(
	parameter bit SUB_GHZ   = 1'b1,
	parameter int TUNE_HOLD = TUNE_HOLD_CYCLES
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// wishbone slave
	input  wire logic [7:0]  ADR_I,
	input  wire logic [31:0] DAT_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic        WE_I,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	output logic             ERR_O,
	// transceiver state and analog handshakes
	input  wire logic [1:0]  TRX_STATE,
	input  wire logic        CAL_DONE,
	input  wire logic        PLL_LOCK,
	// synthesizer control
	output logic             PLL_ENABLE,
	output logic             PLL_TUNE,
	output logic      [31:0] PLL_FREQ,
	// event pulses
	output logic             SYNTH_READY_IRQ,
	output logic             SYNTH_ERROR_IRQ
);

	typedef enum logic [2:0] {
		PLL_OFF,
		PLL_CAL,
		PLL_TUNING,
		PLL_LOCKED,
		PLL_RELOCK
	} pll_state_t;

	// programmed channel registers
	logic [7:0]  channel_spacing_reg, next_channel_spacing_reg;
	logic [7:0]  base_freq_low_reg, next_base_freq_low_reg;
	logic [7:0]  base_freq_high_reg, next_base_freq_high_reg;
	logic [7:0]  channel_low_reg, next_channel_low_reg;
	logic [7:0]  channel_mode_reg, next_channel_mode_reg;
	// active copy driving the synthesizer
	logic [7:0]  act_spacing, next_act_spacing;
	logic [7:0]  act_base_low, next_act_base_low;
	logic [7:0]  act_base_high, next_act_base_high;
	logic [7:0]  act_chan_low, next_act_chan_low;
	logic [1:0]  act_scheme, next_act_scheme;
	logic        act_cnh, next_act_cnh;
	logic        apply, next_apply;
	// bus answer
	logic [31:0] next_dat_o;
	logic        next_ack_o;
	logic        next_err_o;
	// pll tracking
	pll_state_t  pll_state, next_pll_state;
	logic [7:0]  hold_cnt, next_hold_cnt;
	logic        next_pll_enable;
	logic        next_pll_tune;
	logic        next_ready_irq;
	logic        next_error_irq;
	logic [31:0] next_pll_freq;
	// synchronisers and the calculated frequency
	logic [1:0]  lock_sync;
	logic [1:0]  cal_sync;
	logic        locked;
	logic        cal_done;
	logic [31:0] calc_freq;

	// scheme valid for this band: fine 1/2 sub-ghz only, fine 3 2.4ghz only
	function automatic logic scheme_ok(input logic [1:0] s);
		unique case (s)
			SCHEME_IEEE:  return 1'b1;
			SCHEME_FINE1: return SUB_GHZ;
			SCHEME_FINE2: return SUB_GHZ;
			SCHEME_FINE3: return !SUB_GHZ;
		endcase
	endfunction

	// lock and calibration come from the analog side, two flops each
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			lock_sync <= 2'h0;
			cal_sync  <= 2'h0;
		end else begin
			lock_sync <= {lock_sync[0], PLL_LOCK};
			cal_sync  <= {cal_sync[0], CAL_DONE};
		end
	end
	assign locked   = lock_sync[1];
	assign cal_done = cal_sync[1];

	logic req;
	logic wr;
	logic mapped;
	assign req    = CYC_I && STB_I && !ACK_O && !ERR_O;
	assign wr     = req && WE_I && SEL_I[0];
	assign mapped = ADR_I <= OFS_FREQ && ADR_I[1:0] == 2'h0;

	// register writes and the apply event
	always_comb begin
		next_channel_spacing_reg = channel_spacing_reg;
		next_base_freq_low_reg   = base_freq_low_reg;
		next_base_freq_high_reg  = base_freq_high_reg;
		next_channel_low_reg     = channel_low_reg;
		next_channel_mode_reg    = channel_mode_reg;
		next_act_spacing         = act_spacing;
		next_act_base_low        = act_base_low;
		next_act_base_high       = act_base_high;
		next_act_chan_low        = act_chan_low;
		next_act_scheme          = act_scheme;
		next_act_cnh             = act_cnh;
		next_apply               = 1'b0;
		if (wr) begin
			unique case (ADR_I)
				OFS_SPACING:   next_channel_spacing_reg = DAT_I[7:0];
				OFS_BASE_LOW:  next_base_freq_low_reg = DAT_I[7:0];
				OFS_BASE_HIGH: next_base_freq_high_reg = DAT_I[7:0];
				OFS_CHAN_LOW:  next_channel_low_reg = DAT_I[7:0];
				OFS_MODE: begin
					next_channel_mode_reg = DAT_I[7:0] & MODE_WMASK;
					// a scheme the band cannot use leaves the running channel alone
					if (scheme_ok(DAT_I[SCHEME_MSB:SCHEME_LSB])) begin
						next_act_spacing   = channel_spacing_reg;
						next_act_base_low  = base_freq_low_reg;
						next_act_base_high = base_freq_high_reg;
						next_act_chan_low  = channel_low_reg;
						next_act_scheme    = DAT_I[SCHEME_MSB:SCHEME_LSB];
						next_act_cnh       = DAT_I[CNH_BIT];
						next_apply         = 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			channel_spacing_reg <= RST_SPACING;
			base_freq_low_reg   <= RST_BASE_LOW;
			base_freq_high_reg  <= RST_BASE_HIGH;
			channel_low_reg     <= RST_CHAN_LOW;
			channel_mode_reg    <= RST_MODE;
			act_spacing         <= RST_SPACING;
			act_base_low        <= RST_BASE_LOW;
			act_base_high       <= RST_BASE_HIGH;
			act_chan_low        <= RST_CHAN_LOW;
			act_scheme          <= RST_MODE[SCHEME_MSB:SCHEME_LSB];
			act_cnh             <= RST_MODE[CNH_BIT];
			apply               <= 1'b0;
		end else begin
			channel_spacing_reg <= next_channel_spacing_reg;
			base_freq_low_reg   <= next_base_freq_low_reg;
			base_freq_high_reg  <= next_base_freq_high_reg;
			channel_low_reg     <= next_channel_low_reg;
			channel_mode_reg    <= next_channel_mode_reg;
			act_spacing         <= next_act_spacing;
			act_base_low        <= next_act_base_low;
			act_base_high       <= next_act_base_high;
			act_chan_low        <= next_act_chan_low;
			act_scheme          <= next_act_scheme;
			act_cnh             <= next_act_cnh;
			apply               <= next_apply;
		end
	end

	// bus answer one cycle after the request, err for holes in the map
	always_comb begin
		next_ack_o = req && mapped;
		next_err_o = req && !mapped;
		next_dat_o = 32'h0;
		if (req && !WE_I) begin
			unique case (ADR_I)
				OFS_SPACING:   next_dat_o = {24'h0, channel_spacing_reg};
				OFS_BASE_LOW:  next_dat_o = {24'h0, base_freq_low_reg};
				OFS_BASE_HIGH: next_dat_o = {24'h0, base_freq_high_reg};
				OFS_CHAN_LOW:  next_dat_o = {24'h0, channel_low_reg};
				OFS_MODE:      next_dat_o = {24'h0, channel_mode_reg};
				OFS_PLL_STAT: begin
					next_dat_o[STAT_ENABLE_BIT] = PLL_ENABLE;
					next_dat_o[STAT_LOCK_BIT]   = locked;
					next_dat_o[STAT_BUSY_BIT]   = pll_state != PLL_LOCKED && pll_state != PLL_OFF;
				end
				OFS_FREQ:      next_dat_o = PLL_FREQ;
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			DAT_O <= 32'h0;
			ACK_O <= 1'b0;
			ERR_O <= 1'b0;
		end else begin
			DAT_O <= next_dat_o;
			ACK_O <= next_ack_o;
			ERR_O <= next_err_o;
		end
	end

	// frequency of the active copy only; programmed registers never reach it
	channel_freq_calc #(
		.SUB_GHZ (SUB_GHZ)
	) u_calc (
		.scheme    (act_scheme),
		.base_freq ({act_base_high, act_base_low}),
		.chan_num  ({act_cnh, act_chan_low}),
		.spacing   (act_spacing),
		.fine_num  ({act_base_high, act_base_low, act_chan_low}),
		.freq_hz   (calc_freq)
	);

	// pll tracking; a tune start hides lock for a few cycles so a stale lock is not trusted
	always_comb begin
		next_pll_state  = pll_state;
		next_hold_cnt   = hold_cnt == 8'h0 ? 8'h0 : hold_cnt - 8'h1;
		next_pll_tune   = 1'b0;
		next_ready_irq  = 1'b0;
		next_error_irq  = 1'b0;
		next_pll_freq   = calc_freq;
		if (TRX_STATE == transceiver_off_state) begin
			next_pll_state = PLL_OFF;
		end else begin
			unique case (pll_state)
				PLL_OFF: next_pll_state = PLL_CAL;
				PLL_CAL: begin
					if (cal_done) begin
						next_pll_state = PLL_TUNING;
						next_pll_tune  = 1'b1;
						next_hold_cnt  = 8'(TUNE_HOLD);
					end
				end
				PLL_TUNING: begin
					if (apply) begin
						next_pll_tune = 1'b1;
						next_hold_cnt = 8'(TUNE_HOLD);
					end else if (hold_cnt == 8'h0 && locked) begin
						next_pll_state = PLL_LOCKED;
						next_ready_irq = 1'b1;
					end
				end
				PLL_LOCKED: begin
					if (apply) begin
						next_pll_state = PLL_TUNING;
						next_pll_tune  = 1'b1;
						next_hold_cnt  = 8'(TUNE_HOLD);
					end else if (!locked) begin
						next_pll_state = PLL_RELOCK;
						next_error_irq = 1'b1;
					end
				end
				PLL_RELOCK: begin
					if (apply) begin
						next_pll_state = PLL_TUNING;
						next_pll_tune  = 1'b1;
						next_hold_cnt  = 8'(TUNE_HOLD);
					end else if (locked) begin
						next_pll_state = PLL_LOCKED;
						next_ready_irq = 1'b1;
					end
				end
			endcase
		end
		next_pll_enable = next_pll_state != PLL_OFF;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pll_state       <= PLL_OFF;
			hold_cnt        <= 8'h0;
			PLL_ENABLE      <= 1'b0;
			PLL_TUNE        <= 1'b0;
			PLL_FREQ        <= 32'h0;
			SYNTH_READY_IRQ <= 1'b0;
			SYNTH_ERROR_IRQ <= 1'b0;
		end else begin
			pll_state       <= next_pll_state;
			hold_cnt        <= next_hold_cnt;
			PLL_ENABLE      <= next_pll_enable;
			PLL_TUNE        <= next_pll_tune;
			PLL_FREQ        <= next_pll_freq;
			SYNTH_READY_IRQ <= next_ready_irq;
			SYNTH_ERROR_IRQ <= next_error_irq;
		end
	end

endmodule

// ---- tb/synth_channel_config_chk.sv ----
module synth_channel_config_chk
	import synth_pkg::*;
#(
	parameter int TUNE_HOLD = 4
) (
	// clock and reset
	input wire logic        CLK,
	input wire logic        RST_N,
	// wishbone
	input wire logic [7:0]  ADR_I,
	input wire logic [3:0]  SEL_I,
	input wire logic        WE_I,
	input wire logic        CYC_I,
	input wire logic        STB_I,
	input wire logic [31:0] DAT_O,
	input wire logic        ACK_O,
	input wire logic        ERR_O,
	// synthesizer side
	input wire logic [1:0]  TRX_STATE,
	input wire logic        PLL_LOCK,
	input wire logic        PLL_ENABLE,
	input wire logic        PLL_TUNE,
	input wire logic [31:0] PLL_FREQ,
	input wire logic        SYNTH_READY_IRQ,
	input wire logic        SYNTH_ERROR_IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);

	logic       mode_wr;
	logic [1:0] up;
	logic [1:0] next_up;
	logic [7:0] since_tune;
	logic [7:0] next_since_tune;

	// a mode write taken at this edge
	assign mode_wr = CYC_I && STB_I && WE_I && SEL_I[0] && ADR_I == OFS_MODE && !ACK_O && !ERR_O;

	// age since reset masks the reset-to-channel jump; tune age starts saturated
	always_comb begin
		next_up = (up == 2'h3) ? up : up + 2'h1;
		next_since_tune = PLL_TUNE ? 8'h00 : ((since_tune == 8'hff) ? since_tune : since_tune + 8'h01);
	end

	// helper registers
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			up <= 2'h0;
			since_tune <= 8'hff;
		end else begin
			up <= next_up;
			since_tune <= next_since_tune;
		end
	end

	a_ack_single: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
	a_ack_answer: assert property (CYC_I && STB_I && !ACK_O && !ERR_O |=> ACK_O || ERR_O)
		else $error("request not answered next cycle");
	a_ack_cause: assert property (!(CYC_I && STB_I) |=> !ACK_O && !ERR_O) else $error("answer without request");
	a_data_quiet: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("read data outside ack");
	a_off_idle: assert property (TRX_STATE == transceiver_off_state |=> !PLL_ENABLE)
		else $error("synthesizer running while off");
	a_run_enable: assert property (TRX_STATE != transceiver_off_state |=> PLL_ENABLE)
		else $error("synthesizer idle while active");
	// the write is taken at E, the active copy loads at E, PLL_FREQ follows at E+1 and is seen changed at E+2
	a_freq_apply: assert property (up == 2'h3 && $changed(PLL_FREQ) |-> $past(mode_wr, 2))
		else $error("frequency changed without mode write");
	a_tune_single: assert property (PLL_TUNE |=> !PLL_TUNE) else $error("tune pulse too long");
	a_ready_hold: assert property (SYNTH_READY_IRQ |-> since_tune >= TUNE_HOLD && PLL_ENABLE)
		else $error("ready before tune settled");
	a_irq_apart: assert property (!(SYNTH_READY_IRQ && SYNTH_ERROR_IRQ)) else $error("ready and error together");
	a_error_lock: assert property (SYNTH_ERROR_IRQ |-> PLL_ENABLE && !$past(PLL_LOCK))
		else $error("error without lock loss");

	c_error: cover property (SYNTH_ERROR_IRQ);
	c_bus_err: cover property (ERR_O);
	c_rx_tune: cover property (PLL_TUNE && TRX_STATE == TRX_RX);
endmodule

bind synth_channel_config synth_channel_config_chk #(.TUNE_HOLD(TUNE_HOLD)) u_synth_channel_config_chk (
	.CLK(CLK), .RST_N(RST_N), .ADR_I(ADR_I), .SEL_I(SEL_I), .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I),
	.DAT_O(DAT_O), .ACK_O(ACK_O), .ERR_O(ERR_O), .TRX_STATE(TRX_STATE), .PLL_LOCK(PLL_LOCK),
	.PLL_ENABLE(PLL_ENABLE), .PLL_TUNE(PLL_TUNE), .PLL_FREQ(PLL_FREQ),
	.SYNTH_READY_IRQ(SYNTH_READY_IRQ), .SYNTH_ERROR_IRQ(SYNTH_ERROR_IRQ));

// ---- tb/tb_synth_channel_config.sv ----
module tb_synth_channel_config import synth_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic        CLK, RST_N, WE_I, CYC_I, STB_I, ACK_O, ERR_O, CAL_DONE, PLL_LOCK;
	logic        PLL_ENABLE, PLL_TUNE, SYNTH_READY_IRQ, SYNTH_ERROR_IRQ, e;
	logic [7:0]  ADR_I, m[5];
	logic [3:0]  SEL_I;
	logic [1:0]  TRX_STATE;
	logic [31:0] DAT_I, DAT_O, PLL_FREQ, q, f;
	int          fail_count, n_compared, n_tune, n_rdy, n_err, n;

	// short settle hold keeps the run quick
	synth_channel_config #(.TUNE_HOLD(2)) u_synth_channel_config (.CLK(CLK), .RST_N(RST_N), .ADR_I(ADR_I),
		.DAT_I(DAT_I), .SEL_I(SEL_I), .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
		.ERR_O(ERR_O), .TRX_STATE(TRX_STATE), .CAL_DONE(CAL_DONE), .PLL_LOCK(PLL_LOCK), .PLL_ENABLE(PLL_ENABLE),
		.PLL_TUNE(PLL_TUNE), .PLL_FREQ(PLL_FREQ), .SYNTH_READY_IRQ(SYNTH_READY_IRQ),
		.SYNTH_ERROR_IRQ(SYNTH_ERROR_IRQ));

	always #5 CLK = ~CLK;

	// pulse tallies
	always @(posedge CLK) begin
		n_tune += int'(PLL_TUNE === 1'b1);
		n_rdy += int'(SYNTH_READY_IRQ === 1'b1);
		n_err += int'(SYNTH_ERROR_IRQ === 1'b1);
	end

	task results();
		if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task pause(input int c);
		repeat (c) @(posedge CLK);
	endtask

	// one classic cycle; waits for ack or err under a bound
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge CLK);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I <= w;
		ADR_I <= a;
		DAT_I <= d;
		SEL_I <= 4'h1;
		k = 0;
		do begin
			@(posedge CLK);
			k++;
		end while (ACK_O !== 1'b1 && ERR_O !== 1'b1 && k < 20);
		if (k >= 20) fail_count++;
		q = DAT_O;
		e = ERR_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
	endtask

	// frequency the applied settings should give
	function automatic logic [31:0] calc(input logic [7:0] md);
		longint x;
		x = {m[2], m[1], m[3]};
		case (md[7:6])
			2'h0: calc = 32'((longint'({m[2], m[1]}) + longint'({md[0], m[3]}) * m[0]) * 25000);
			2'h1: calc = 32'(377000000 + ((6500000 * x) >> 16));
			2'h2: calc = 32'(754000000 + ((13000000 * x) >> 16));
			default: calc = f; // scheme for the other band is not applied
		endcase
	endfunction

	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, {24'($urandom), d}); // upper bits are random and must be ignored
		if (a == OFS_MODE) begin
			f = calc(d);
			m[4] = d & MODE_WMASK;
		end else m[a[4:2]] = d;
	endtask

	// full programming sequence, mode register last
	task setch(input logic [7:0] cs, input logic [7:0] bl, input logic [7:0] bh, input logic [7:0] cl,
		input logic [7:0] md);
		wr(OFS_SPACING, cs);
		wr(OFS_BASE_LOW, bl);
		wr(OFS_BASE_HIGH, bh);
		wr(OFS_CHAN_LOW, cl);
		check(PLL_FREQ, f);
		wr(OFS_MODE, md);
		pause(2);
		check(PLL_FREQ, f);
		bus(OFS_FREQ, 1'b0, 32'h0);
		check(q, f);
		bus(OFS_MODE, 1'b0, 32'h0);
		check(q, {24'h0, m[4]});
	endtask

	initial begin
		repeat (20000) @(posedge CLK);
		fail_count++;
		results();
	end

	initial begin
		{CLK, RST_N, WE_I, CYC_I, STB_I, CAL_DONE, PLL_LOCK} = '0;
		{ADR_I, SEL_I, DAT_I} = '0;
		TRX_STATE = transceiver_off_state;
		m = '{RST_SPACING, RST_BASE_LOW, RST_BASE_HIGH, RST_CHAN_LOW, RST_MODE};
		f = 32'd902200000;
		void'($urandom(10));
		pause(12);
		RST_N <= 1'b1;
		@(posedge CLK);
		for (int i = 0; i < 5; i++) begin
			bus(8'(i * 4), 1'b0, 32'h0);
			check(q, {24'h0, m[i]});
		end
		bus(8'h1c, 1'b0, 32'h0);
		check(32'(e), 32'h1);
		bus(8'h05, 1'b0, 32'h0);
		check(32'(e), 32'h1);
		check(PLL_FREQ, f);
		// base and spacing kept so every channel stays inside the upper sub-ghz range
		for (int i = 0; i < 6; i++) begin
			n = 31160 + $urandom_range(4000);
			setch(8'($urandom_range(8)), 8'(n), 8'(n >> 8), 8'($urandom), {2'h0, 6'($urandom)});
		end
		for (int s = 1; s < 4; s++) begin
			n = $urandom_range(1340967, 126030);
			setch(8'($urandom), 8'(n >> 8), 8'(n >> 16), 8'(n), {2'(s), 6'($urandom)});
		end
		CAL_DONE <= 1'b1;
		PLL_LOCK <= 1'b1;
		TRX_STATE <= transmit_prepare_state;
		pause(20);
		check(n_tune, 1);
		check(n_rdy, 1);
		bus(OFS_PLL_STAT, 1'b0, 32'h0);
		check(q, 32'h3);
		setch(8'h08, 8'hf8, 8'h8c, 8'h02, 8'h00);
		pause(20);
		check(n_tune, 2);
		check(n_rdy, 2);
		PLL_LOCK <= 1'b0;
		pause(10);
		check(n_err, 1);
		check(32'(PLL_ENABLE), 32'h1);
		bus(OFS_PLL_STAT, 1'b0, 32'h0);
		check(q & 32'h3, 32'h1);
		PLL_LOCK <= 1'b1;
		pause(10);
		check(n_rdy, 3);
		TRX_STATE <= transceiver_off_state;
		pause(3);
		check(32'(PLL_ENABLE), 32'h0);
		TRX_STATE <= TRX_RX;
		pause(20);
		check(n_tune, 3);
		check(n_rdy, 4);
		TRX_STATE <= TRX_TX;
		pause(3);
		check(32'(PLL_ENABLE), 32'h1);
		TRX_STATE <= transceiver_off_state;
		pause(3);
		results();
	end
endmodule
